/* inc/ccao_params.svh */
`ifndef CCAO_PARAMS_SVH
`define CCAO_PARAMS_SVH
`define CCAO_CDATA_W 8
`define CCAO_NIB_W 4
`define CCAO_PAR_HI 7
`define CCAO_PAR_LO 4
`define CCAO_RST_HOLD_MON 1'b0
`define CCAO_RST_CACHEABLE_N 1'b1
`define CCAO_RST_DNC 1'b1
`define CCAO_RST_STROBE_N 1'b1
`endif

/* inc/ccao_pkg.sv */
package ccao_pkg;
  typedef enum logic [2:0]
  {
    CCAO_IDLE = 3'b001,
    CCAO_CPU = 3'b010,
    CCAO_OWN = 3'b100
  } ccao_cyc_e;
  typedef struct packed
  {
    ccao_cyc_e cyc;
    logic strobe_n;
    logic cacheable_n;
    logic dnc;
    logic bist_fail;
    logic bist_seen;
  } ccao_attr_s;
  typedef struct packed
  {
    logic [7:0] rd;
    logic [7:0] wr;
    logic wr_valid;
  } ccao_sram_s;
endpackage

/* src/ccao_sram_slice.sv */
`timescale 1ns/1ns
`include "ccao_params.svh"
module ccao_sram_slice
  import ccao_pkg::*;
#(
  parameter int DATA_W = `CCAO_CDATA_W
)
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic burst_ready_copy_n_in,
  input wire logic write_cycle_in,
  input wire logic narrow_cfg_in,
  input wire logic parity_cfg_in,
  input wire logic [DATA_W-1:0] array_rd_in,
  input wire logic [DATA_W-1:0] cdata_in,
  input wire logic [7:0] cpu_byte_enables_n_in,
  input wire logic [7:0] cpu_data_parity_in,
  output logic [DATA_W-1:0] cdata_out,
  output logic cdata_oe_n_out,
  output logic [DATA_W-1:0] wr_data_out,
  output logic wr_valid_out
);
  ccao_sram_s st_reg;
  ccao_sram_s st_next;
  logic [DATA_W-1:0] mask;

  always_comb
  begin
    st_next = st_reg;
    st_next.wr_valid = 1'b0;
    mask = narrow_cfg_in ? DATA_W'(8'h0F) : {DATA_W{1'b1}};
    // (R15) drive on copy strobe
    if (!burst_ready_copy_n_in && !write_cycle_in)
    begin
      st_next.rd = 8'(array_rd_in & mask);
    end
    // (R15) capture on copy strobe
    if (!burst_ready_copy_n_in && write_cycle_in)
    begin
      st_next.wr_valid = 1'b1;
      // (R16) parity slice mapping
      if (parity_cfg_in)
      begin
        st_next.wr = {cpu_byte_enables_n_in[3:0], cpu_data_parity_in[3:0]};
      end
      else
      begin
        // (R14) narrow uses low nibble
        st_next.wr = 8'(cdata_in & mask);
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // (R15) enable only in copy clock
  assign cdata_oe_n_out = !(!burst_ready_copy_n_in && !write_cycle_in);
  assign cdata_out = DATA_W'(st_next.rd);
  assign wr_data_out = DATA_W'(st_reg.wr);
  assign wr_valid_out = st_reg.wr_valid;
endmodule

/* src/ccao_cycle_attr.sv */
`timescale 1ns/1ns
`include "ccao_params.svh"
// Contract
// (R1) monitor mirrors address hold, no delay
// (R2) bus controller may watch hold monitor
// (R3) after self-test monitor shows pass/fail
// (R4) self-test error drives monitor low immediately
// (R5) monitor always at defined level
// (R6) latched cacheable follows cpu cacheable
// (R7) controller ignores cacheable on own cycles
// (R8) controller picks one or four burst-readies
// (R9) cacheable held from strobe to ready
// (R10) data/code high on own cycles
// (R11) data/code shows data versus code
// (R12) data/code valid strobe through ready
// (R13) attributes valid with address strobe
// (R14) narrow config uses data bits 3-0
// (R15) sram data in burst-ready copy clock
// (R16) parity slice: enables high, parity low
// (R17) strobe one clock, always valid
// (R18) capture cacheable at issue, hold it
module ccao_cycle_attr
  import ccao_pkg::*;
#(
  parameter int DATA_W = `CCAO_CDATA_W
)
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic cpu_address_hold_in,
  input wire logic selftest_active_in,
  input wire logic selftest_error_in,
  input wire logic selftest_flush_done_n_in,
  input wire logic cpu_cycle_issue_in,
  input wire logic own_cycle_issue_in,
  input wire logic snoop_issue_in,
  input wire logic cpu_cacheable_n_in,
  input wire logic cpu_data_not_code_in,
  input wire logic cycle_ready_n_in,
  input wire logic cycle_next_address_n_in,
  input wire logic cpu_burst_ready_copy_n_in,
  input wire logic write_cycle_in,
  input wire logic narrow_cfg_in,
  input wire logic parity_cfg_in,
  input wire logic [DATA_W-1:0] array_rd_in,
  input wire logic [DATA_W-1:0] sram_cpu_side_data_in,
  input wire logic [7:0] cpu_byte_enables_n_in,
  input wire logic [7:0] cpu_data_parity_in,
  output logic hold_monitor_out,
  output logic cycle_address_strobe_n_out,
  output logic latched_cacheable_n_out,
  output logic cycle_data_not_code_out,
  output logic cycle_busy_out,
  output logic [DATA_W-1:0] sram_cpu_side_data_out,
  output logic sram_cpu_side_data_oe_n_out,
  output logic [DATA_W-1:0] sram_wr_data_out,
  output logic sram_wr_valid_out
);
  ccao_attr_s st_reg;
  ccao_attr_s st_next;
  logic cycle_end;
  logic issue_any;

  always_comb
  begin
    st_next = st_reg;
    cycle_end = !cycle_ready_n_in || !cycle_next_address_n_in;
    issue_any = cpu_cycle_issue_in || own_cycle_issue_in || snoop_issue_in;
    // (R17) strobe lasts one clock
    st_next.strobe_n = `CCAO_RST_STROBE_N;
    // (R4) sticky self-test error
    if (selftest_active_in && selftest_error_in)
    begin
      st_next.bist_fail = 1'b1;
    end
    if (selftest_active_in)
    begin
      st_next.bist_seen = 1'b1;
    end
    unique case (st_reg.cyc)
      CCAO_IDLE:
      begin
        if (issue_any)
        begin
          // (R17) assert strobe for one clock
          st_next.strobe_n = !(cpu_cycle_issue_in || own_cycle_issue_in);
          // (R18) capture cacheable at issue
          if (cpu_cycle_issue_in)
          begin
            st_next.cyc = CCAO_CPU;
            st_next.cacheable_n = cpu_cacheable_n_in;
            // (R11) data or code
            st_next.dnc = cpu_data_not_code_in;
          end
          else
          begin
            st_next.cyc = CCAO_OWN;
            // (R10) own cycles are data
            st_next.dnc = 1'b1;
          end
        end
      end
      CCAO_CPU, CCAO_OWN:
      begin
        // (R9) hold until ready or next address
        if (cycle_end)
        begin
          st_next.cyc = CCAO_IDLE;
        end
      end
      default:
      begin
        st_next.cyc = CCAO_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      st_reg.cyc <= CCAO_IDLE;
      st_reg.strobe_n <= `CCAO_RST_STROBE_N;
      st_reg.cacheable_n <= `CCAO_RST_CACHEABLE_N;
      st_reg.dnc <= `CCAO_RST_DNC;
      st_reg.bist_fail <= 1'b0;
      st_reg.bist_seen <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // (R1) mirror hold outside self-test
  // (R3) result after self-test: high pass
  // (R4) low at once on error
  // (R5) never undefined
  always_comb
  begin
    if (selftest_active_in)
    begin
      hold_monitor_out = !(st_reg.bist_fail || selftest_error_in);
    end
    else if (!selftest_flush_done_n_in && st_reg.bist_seen)
    begin
      hold_monitor_out = !st_reg.bist_fail;
    end
    else
    begin
      hold_monitor_out = cpu_address_hold_in;
    end
  end

  // (R13) attributes valid with strobe
  assign cycle_address_strobe_n_out = st_reg.strobe_n;
  // (R6) follow latched cacheable
  assign latched_cacheable_n_out = st_reg.cacheable_n;
  // (R12) valid through ready
  assign cycle_data_not_code_out = st_reg.dnc;
  assign cycle_busy_out = st_reg.cyc != CCAO_IDLE;

  ccao_sram_slice #(
    .DATA_W(DATA_W)
  ) u_slice (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .burst_ready_copy_n_in(cpu_burst_ready_copy_n_in),
    .write_cycle_in(write_cycle_in),
    .narrow_cfg_in(narrow_cfg_in),
    .parity_cfg_in(parity_cfg_in),
    .array_rd_in(array_rd_in),
    .cdata_in(sram_cpu_side_data_in),
    .cpu_byte_enables_n_in(cpu_byte_enables_n_in),
    .cpu_data_parity_in(cpu_data_parity_in),
    .cdata_out(sram_cpu_side_data_out),
    .cdata_oe_n_out(sram_cpu_side_data_oe_n_out),
    .wr_data_out(sram_wr_data_out),
    .wr_valid_out(sram_wr_valid_out)
  );
endmodule

/* bench/ccao_cycle_attr_sva.sv */
`timescale 1ns/1ns
module ccao_cycle_attr_sva
(
  input wire logic clock_in, srst_in, cpu_address_hold_in, selftest_active_in, selftest_error_in,
  input wire logic selftest_flush_done_n_in, cpu_cycle_issue_in, own_cycle_issue_in, cpu_cacheable_n_in,
  input wire logic cycle_ready_n_in, hold_monitor_out, cycle_address_strobe_n_out, latched_cacheable_n_out,
  input wire logic cycle_data_not_code_out, cycle_busy_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  sequence s_open;
    !cycle_address_strobe_n_out && cycle_busy_out ##1 cycle_address_strobe_n_out;
  endsequence
  AST_MIRROR:
  assert property (!selftest_active_in && selftest_flush_done_n_in |-> hold_monitor_out == cpu_address_hold_in)
    else $error("mirror");
  AST_BIST:
  assert property (selftest_active_in && selftest_error_in |-> !hold_monitor_out) else $error("bist");
  AST_TAKE:
  assert property ((cpu_cycle_issue_in || own_cycle_issue_in) && !cycle_busy_out |=> s_open) else $error("take");
  AST_IDLE:
  assert property (!cycle_busy_out |-> cycle_address_strobe_n_out) else $error("idle");
  AST_CACHE:
  assert property (cpu_cycle_issue_in && !cycle_busy_out |=> latched_cacheable_n_out == $past(cpu_cacheable_n_in))
    else $error("cache");
  AST_OWN:
  assert property (own_cycle_issue_in && !cycle_busy_out |=> cycle_data_not_code_out) else $error("own");
  AST_HOLD:
  assert property (cycle_busy_out && $past(cycle_busy_out) |-> $stable({latched_cacheable_n_out, cycle_data_not_code_out}))
    else $error("hold");
  AST_END:
  assert property (cycle_busy_out && !cycle_ready_n_in |=> !cycle_busy_out) else $error("end");
endmodule
bind ccao_cycle_attr ccao_cycle_attr_sva u_sva (.*);

/* bench/ccao_mbc_model.sv */
`timescale 1ns/1ns
module ccao_mbc_model
(
  input wire logic clock_in, srst_in, cycle_address_strobe_n_out, latched_cacheable_n_out,
  input wire logic cycle_data_not_code_out, ro,
  input wire logic [3:0] dly,
  output logic cycle_ready_n_in,
  output logic [2:0] bursts
);
  logic [3:0] cnt_reg;
  always_ff @(posedge clock_in)
  begin
    cycle_ready_n_in <= cnt_reg != 4'h1 || srst_in;
    if (!cycle_address_strobe_n_out)
      bursts <= latched_cacheable_n_out || ro && cycle_data_not_code_out ? 3'h1 : 3'h4;
    cnt_reg <= srst_in ? 4'h0 : !cycle_address_strobe_n_out ? dly : cnt_reg - 4'(cnt_reg != 4'h0);
  end
endmodule

/* bench/ccao_cycle_attr_bench.sv */
`timescale 1ns/1ns
module ccao_cycle_attr_bench;
  bit clock_in, cpu_address_hold_in, selftest_active_in, selftest_error_in, cpu_cycle_issue_in, own_cycle_issue_in;
  bit snoop_issue_in, cpu_data_not_code_in, write_cycle_in, narrow_cfg_in, parity_cfg_in, ro;
  bit srst_in = 1'h1, selftest_flush_done_n_in = 1'h1, cpu_cacheable_n_in = 1'h1, cycle_next_address_n_in = 1'h1;
  bit cpu_burst_ready_copy_n_in = 1'h1;
  bit [7:0] array_rd_in, sram_cpu_side_data_in, cpu_byte_enables_n_in, cpu_data_parity_in;
  bit [3:0] dly;
  logic hold_monitor_out, cycle_address_strobe_n_out, latched_cacheable_n_out, cycle_data_not_code_out;
  logic cycle_busy_out, sram_cpu_side_data_oe_n_out, sram_wr_valid_out, cycle_ready_n_in;
  logic [7:0] sram_cpu_side_data_out, sram_wr_data_out;
  logic [2:0] bursts;
  bit [5:0] rows [6] = '{6'h04, 6'h14, 6'h21, 6'h0C, 6'h19, 6'h39};
  int num_errors, checks;
  ccao_cycle_attr u_ccao_cycle_attr (.*);
  ccao_mbc_model u_ccao_mbc_model (.*);
  always #4 clock_in = ~clock_in;
  task automatic chk(string n, logic [7:0] s, e);
    checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic go(bit own, c, d);
    @(posedge clock_in);
    {own_cycle_issue_in, cpu_cycle_issue_in, cpu_cacheable_n_in, cpu_data_not_code_in} <= {own, !own, c, d};
    @(posedge clock_in);
    {own_cycle_issue_in, cpu_cycle_issue_in} <= 2'h0;
    @(negedge clock_in);
  endtask
  task automatic drain;
    for (int i = 0; i < 30 && cycle_busy_out !== 1'h0; i++)
      @(negedge clock_in);
    chk("busy", cycle_busy_out, 0);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #20000;
    num_errors++;
    wrap_up;
  end
  initial
  begin
    repeat (20) @(posedge clock_in);
    {srst_in, cpu_address_hold_in} <= 2'h1;
    foreach (rows[i])
    begin
      ro = rows[i][3];
      dly = 4'(i + 1);
      go(1'h0, rows[i][5], rows[i][4]);
      chk("cache", latched_cacheable_n_out, rows[i][5]);
      chk("dnc", cycle_data_not_code_out, rows[i][4]);
      chk("mirror", hold_monitor_out, 1);
      drain;
      chk("bursts", bursts, rows[i][2:0]);
    end
    $display("rows done");
    go(1'h0, 1'h0, 1'h0);
    go(1'h1, 1'h1, 1'h1);
    chk("refused", {latched_cacheable_n_out, cycle_data_not_code_out}, 0);
    drain;
    go(1'h1, 1'h0, 1'h0);
    chk("own", cycle_data_not_code_out, 1);
    drain;
    $display("order done");
    @(posedge clock_in);
    {parity_cfg_in, write_cycle_in, cpu_burst_ready_copy_n_in} <= 3'h6;
    {cpu_byte_enables_n_in, cpu_data_parity_in} <= 16'hA53C;
    @(posedge clock_in);
    {cpu_burst_ready_copy_n_in, cpu_address_hold_in, selftest_active_in} <= 3'h5;
    @(negedge clock_in);
    chk("par", sram_wr_data_out, 8'h5C);
    chk("wrv", sram_wr_valid_out, 1);
    @(posedge clock_in);
    {selftest_active_in, selftest_flush_done_n_in} <= 2'h0;
    @(negedge clock_in);
    chk("pass", hold_monitor_out, 1);
    @(posedge clock_in);
    {selftest_active_in, selftest_error_in} <= 2'h3;
    @(negedge clock_in);
    chk("err", hold_monitor_out, 0);
    $display("bist done");
    @(posedge clock_in);
    {selftest_active_in, selftest_error_in, write_cycle_in, narrow_cfg_in, cpu_burst_ready_copy_n_in} <= 5'h2;
    array_rd_in <= 8'hA7;
    @(negedge clock_in);
    chk("oe", sram_cpu_side_data_oe_n_out, 0);
    chk("rdnib", sram_cpu_side_data_out, 8'h07);
    @(posedge clock_in);
    {cpu_burst_ready_copy_n_in, srst_in} <= 2'h3;
    @(posedge clock_in);
    @(negedge clock_in);
    chk("rst", {cycle_address_strobe_n_out, latched_cacheable_n_out, cycle_data_not_code_out, cycle_busy_out}, 8'hE);
    @(posedge clock_in);
    srst_in <= 1'h0;
    go(1'h0, 1'h1, 1'h0);
    chk("after rst", latched_cacheable_n_out, 1);
    $display("reset done");
    wrap_up;
  end
endmodule
